// ---- hdl/pci_master_initiator.sv ----
// PCI initiator: arbitration, address, command and burst sizing.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pci_master_initiator
(
  // System clock and reset.
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // APB slave.
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Source request.
  input  wire logic                       srcReq,
  input  wire pci_master_pkg::source_e    srcKind,
  input  wire logic                       srcWrite,
  input  wire logic                       srcIo,
  input  wire logic                       srcCfg,
  input  wire logic [31:0]                srcAddr,
  input  wire logic [7:0]                 srcLen,
  input  wire logic                       srcTranslate,
  input  wire logic [31:0]                srcBlockMask,
  input  wire logic [31:0]                srcOffset,
  input  wire logic [63:0]                srcWdata,
  output logic                            srcAccept,
  output logic                            srcBeat,
  output logic                            srcDone,
  output logic                            srcStopped,
  output logic                            srcAbort,
  output logic      [63:0]                srcRdata,
  // Target side status.
  input  wire logic                       targetBusy,
  output logic                            masterActive,
  // PCI link pins.
  input  wire logic                       pciClk,
  input  wire logic                       bus_grant_n,
  input  wire logic                       peerReq_n,
  input  wire logic                       devsel_n,
  input  wire logic                       trdy_n,
  input  wire logic                       stop_n,
  input  wire logic                       frame_n_i,
  input  wire logic [63:0]                ad_i,
  output logic                            req_n,
  output logic                            peerGrant_n,
  output logic                            frame_n_o,
  output logic                            frame_n_oe,
  output logic                            irdy_n_o,
  output logic                            irdy_n_oe,
  output logic      [3:0]                 command_byte_enable_n_o,
  output logic                            command_byte_enable_n_oe,
  output logic      [63:0]                ad_o,
  output logic                            ad_oe
);
  import pci_master_pkg::*;

  // Beat count of a transfer of len bytes on the present bus width.
  function automatic logic [5:0] beatsOf(input logic [7:0] len, input logic wide);
    logic [7:0] b;
    b = wide ? {3'b000, len[7:3]} + {7'b0, |len[2:0]}
             : {2'b00, len[7:2]} + {7'b0, |len[1:0]};
    return (b == 8'h00) ? 6'd1 : b[5:0];
  endfunction : beatsOf

  // Command code from direction, space and length.
  function automatic logic [3:0] cmdOf(input logic wr, input logic io,
                                       input logic cfg, input logic [7:0] len,
                                       input logic [7:0] cls);
    logic [3:0] c;
    if (cfg)
      c = wr ? CMD_CFG_WRITE : CMD_CFG_READ;
    else if (io)
      c = wr ? CMD_IO_WRITE : CMD_IO_READ;
    else if (wr)
      c = CMD_MEM_WRITE;
    else if (len <= SINGLE_LEN)
      c = CMD_MEM_READ;
    else if (len <= cls)
      c = CMD_MEM_RD_LN;
    else
      c = CMD_MEM_RD_MUL;
    return c;
  endfunction : cmdOf

  // Registers.
  logic [4:0]  ctrl_q;
  logic [7:0]  cls_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  state_e      state_q;
  logic [5:0]  beatsLeft_q;
  logic [2:0]  devselCnt_q;
  logic [1:0]  holdoff_q;
  logic        isWrite_q;
  logic        ownGrant_q;
  logic        peerGrantN_q;
  logic        reqN_q;
  logic        frameN_q;
  logic        frameOe_q;
  logic        irdyN_q;
  logic        irdyOe_q;
  logic [3:0]  cbe_q;
  logic        cbeOe_q;
  logic [63:0] ad_q;
  logic        adOe_q;
  logic        accept_q;
  logic        beat_q;
  logic        done_q;
  logic        stopped_q;
  logic        abort_q;
  logic [63:0] rdata_q;
  logic [3:0]  cmd_q;
  logic [31:0] addr_q;

  // Link synchronisers: stage one feeds stage two only.
  logic [6:0]  linkS1_q;
  logic [6:0]  linkS2_q;
  logic        clkPrev_q;
  logic [63:0] adS1_q;
  logic [63:0] adS2_q;

  always_ff @(posedge sys_clk)
  begin
    linkS1_q  <= {pciClk, bus_grant_n, peerReq_n, devsel_n, trdy_n, stop_n, frame_n_i};
    linkS2_q  <= linkS1_q;
    clkPrev_q <= linkS2_q[6];
    adS1_q    <= ad_i;
    adS2_q    <= adS1_q;
  end

  // Synchronised link signals and decode.
  wire         pciRise   = linkS2_q[6] & ~clkPrev_q;
  wire         gntN      = linkS2_q[5];
  wire         peerReqN  = linkS2_q[4];
  wire         devselN   = linkS2_q[3];
  wire         trdyN     = linkS2_q[2];
  wire         stopN     = linkS2_q[1];
  wire         busFrameN = linkS2_q[0];
  wire         initEn    = ctrl_q[INIT_EN_BIT];
  wire         arbEn     = ctrl_q[ARB_EN_BIT];
  wire         extEn     = ctrl_q[EXT_CYC_BIT];
  wire         wide      = ctrl_q[BUS64_BIT];
  wire         grantOk   = arbEn ? ownGrant_q : ~gntN;
  wire         busIdle   = busFrameN & frameN_q;
  wire         isExt     = (srcLen == EXT16_LEN) || (srcLen == EXT24_LEN);
  wire [7:0]   dmaLen    = (srcLen > DMA_MAX_LEN) ? DMA_MAX_LEN : srcLen;
  wire [7:0]   beatLen   = wide ? BEAT64_LEN : BEAT32_LEN;
  wire [31:0]  xlatAddr  = (srcAddr & srcBlockMask) | (srcOffset & ~srcBlockMask);
  wire [31:0]  pciAddr   = srcTranslate ? xlatAddr : srcAddr;

  // Effective write length per source.
  logic [7:0] effLen;
  always_comb
  begin
    effLen = srcLen;
    if (srcIo && srcWrite)
      effLen = beatLen;
    else if (srcKind == SRC_DMA && srcWrite)
      effLen = dmaLen;
    else if (srcKind == SRC_PROC && srcWrite && isExt && !extEn)
      effLen = SINGLE_LEN;
  end

  // Beats per transfer; 32 bytes give 4 or 8, 8 bytes give 1 or 2.
  wire [5:0] effBeats = beatsOf(effLen, wide);
  wire [3:0] effCmd   = cmdOf(srcWrite, srcIo, srcCfg, srcLen, cls_q);
  wire       startOk  = srcReq && initEn && !targetBusy
                        && holdoff_q == 2'd0;

  // APB decode.
  wire        apbAccess = psel & penable & pready_q;
  wire        apbWrite  = apbAccess & pwrite;
  wire        hitCtrl   = paddr == CTRL_OFFSET;
  wire        hitCls    = paddr == CACHE_LINE_OFFSET;
  wire        hitStat   = paddr == STATUS_OFFSET;
  wire        mapped    = hitCtrl | hitCls | hitStat;
  wire        clsLegal  = pwdata[7:0] == CLS_16 || pwdata[7:0] == CLS_32
                          || pwdata[7:0] == CLS_64 || pwdata[7:0] == CLS_128;
  wire [31:0] statWord  = {24'h0, beatsLeft_q, ~reqN_q | ownGrant_q, masterActive};
  wire [31:0] readMux   = hitCtrl ? {27'h0, 1'b0, ctrl_q[3:0]} :
                          hitCls  ? {24'h0, cls_q} :
                          hitStat ? statWord : 32'h0000_0000;

  // Single wait state on every access keeps read data registered.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? readMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_q <= CTRL_RESET;
      cls_q  <= CACHE_LINE_RESET;
    end
    else
    begin
      if (apbWrite && hitCtrl)
        ctrl_q <= {1'b0, pwdata[3:0]};
      if (apbWrite && hitCls && clsLegal)
        cls_q <= pwdata[7:0];
    end
  end

  // Internal arbiter: grant moves only while the bus idles and stays where it is while the bus is busy.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ownGrant_q   <= 1'b0;
      peerGrantN_q <= 1'b1;
    end
    else if (!arbEn)
    begin
      ownGrant_q   <= 1'b0;
      peerGrantN_q <= 1'b1;
    end
    else if (pciRise && busIdle)
    begin
      if (state_q == ST_REQ)
      begin
        ownGrant_q   <= 1'b1;
        peerGrantN_q <= 1'b1;
      end
      else if (!peerReqN)
      begin
        ownGrant_q   <= 1'b0;
        peerGrantN_q <= 1'b0;
      end
      else if (!ownGrant_q && peerGrantN_q)
        ownGrant_q <= 1'b1;
    end
  end

  // Master sequencer, stepping on each rising link clock edge.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q     <= ST_IDLE;
      beatsLeft_q <= 6'd0;
      devselCnt_q <= 3'd0;
      holdoff_q   <= 2'd0;
      isWrite_q   <= 1'b0;
      cmd_q       <= 4'h0;
      addr_q      <= 32'h0000_0000;
      reqN_q      <= 1'b1;
      frameN_q    <= 1'b1;
      frameOe_q   <= 1'b0;
      irdyN_q     <= 1'b1;
      irdyOe_q    <= 1'b0;
      cbe_q       <= 4'hF;
      cbeOe_q     <= 1'b0;
      ad_q        <= 64'h0000_0000_0000_0000;
      adOe_q      <= 1'b0;
      accept_q    <= 1'b0;
      beat_q      <= 1'b0;
      done_q      <= 1'b0;
      stopped_q   <= 1'b0;
      abort_q     <= 1'b0;
      rdata_q     <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      accept_q <= 1'b0;
      beat_q   <= 1'b0;
      done_q   <= 1'b0;
      if (pciRise)
      begin
        if (holdoff_q != 2'd0)
          holdoff_q <= holdoff_q - 2'd1;
        case (state_q)
          ST_IDLE:
          begin
            if (startOk)
            begin
              isWrite_q   <= srcWrite;
              cmd_q       <= effCmd;
              addr_q      <= pciAddr;
              beatsLeft_q <= effBeats;
              accept_q    <= 1'b1;
              reqN_q      <= arbEn;
              stopped_q   <= 1'b0;
              abort_q     <= 1'b0;
              state_q     <= ST_REQ;
            end
          end
          ST_REQ:
          begin
            if (!initEn)
            begin
              reqN_q  <= 1'b1;
              state_q <= ST_IDLE;
            end
            else if (grantOk && busIdle && !targetBusy)
            begin
              frameN_q  <= 1'b0;
              frameOe_q <= 1'b1;
              irdyOe_q  <= 1'b1;
              cbe_q     <= cmd_q;
              cbeOe_q   <= 1'b1;
              ad_q      <= {32'h0000_0000, addr_q};
              adOe_q    <= 1'b1;
              reqN_q    <= 1'b1;
              state_q   <= ST_ADDR;
            end
          end
          ST_ADDR:
          begin
            irdyN_q     <= 1'b0;
            frameN_q    <= beatsLeft_q == 6'd1;
            cbe_q       <= 4'h0;
            ad_q        <= srcWdata;
            adOe_q      <= isWrite_q;
            devselCnt_q <= 3'd0;
            state_q     <= ST_DATA;
          end
          ST_DATA:
          begin
            if (devselN && devselCnt_q == DEVSEL_TIMEOUT)
            begin
              frameN_q <= 1'b1;
              irdyN_q  <= 1'b1;
              abort_q  <= 1'b1;
              state_q  <= ST_TURN;
            end
            else
            begin
              if (devselN)
                devselCnt_q <= devselCnt_q + 3'd1;
              if (!devselN && !trdyN)
              begin
                beat_q  <= 1'b1;
                rdata_q <= adS2_q;
                ad_q    <= srcWdata;
                if (beatsLeft_q != 6'd0)
                  beatsLeft_q <= beatsLeft_q - 6'd1;
              end
              if (!stopN || (!devselN && !trdyN && beatsLeft_q <= 6'd1))
              begin
                frameN_q  <= 1'b1;
                irdyN_q   <= 1'b1;
                stopped_q <= ~stopN && beatsLeft_q > 6'd1;
                holdoff_q <= stopN ? 2'd0 : STOP_HOLDOFF;
                state_q   <= ST_TURN;
              end
              else if (!devselN && !trdyN && beatsLeft_q == 6'd2)
                frameN_q <= 1'b1;
            end
          end
          ST_TURN:
          begin
            frameOe_q <= 1'b0;
            irdyOe_q  <= 1'b0;
            cbeOe_q   <= 1'b0;
            cbe_q     <= 4'hF;
            adOe_q    <= 1'b0;
            done_q    <= 1'b1;
            state_q   <= ST_IDLE;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Output drive, all from flip-flops.
  wire activeNow = state_q != ST_IDLE;
  logic active_q;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      active_q <= 1'b0;
    else
      active_q <= activeNow;
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign srcAccept                = accept_q;
  assign srcBeat                  = beat_q;
  assign srcDone                  = done_q;
  assign srcStopped               = stopped_q;
  assign srcAbort                 = abort_q;
  assign srcRdata                 = rdata_q;
  assign masterActive             = active_q;
  assign req_n                    = reqN_q;
  assign peerGrant_n              = peerGrantN_q;
  assign frame_n_o                = frameN_q;
  assign frame_n_oe               = frameOe_q;
  assign irdy_n_o                 = irdyN_q;
  assign irdy_n_oe                = irdyOe_q;
  assign command_byte_enable_n_o  = cbe_q;
  assign command_byte_enable_n_oe = cbeOe_q;
  assign ad_o                     = ad_q;
  assign ad_oe                    = adOe_q;
endmodule : pci_master_initiator
`default_nettype wire

// ---- common/pci_master_pkg.sv ----
// Constants shared by the PCI initiator block and its bench.
package pci_master_pkg;
  // Register byte offsets on the APB side.
  localparam logic [11:0] CTRL_OFFSET       = 12'h000;
  localparam logic [11:0] CACHE_LINE_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET     = 12'h008;
  // Control register field positions.
  localparam int INIT_EN_BIT   = 0;
  localparam int ARB_EN_BIT    = 1;
  localparam int EXT_CYC_BIT   = 2;
  localparam int BUS64_BIT     = 3;
  localparam int WR_INV_BIT    = 4;
  // Reset values.
  localparam logic [4:0] CTRL_RESET       = 5'h00;
  localparam logic [7:0] CACHE_LINE_RESET = 8'h20;
  // Legal cache line sizes in bytes.
  localparam logic [7:0] CLS_16  = 8'h10;
  localparam logic [7:0] CLS_32  = 8'h20;
  localparam logic [7:0] CLS_64  = 8'h40;
  localparam logic [7:0] CLS_128 = 8'h80;
  // Lengths in bytes.
  localparam logic [7:0] SINGLE_LEN  = 8'h08;
  localparam logic [7:0] EXT16_LEN   = 8'h10;
  localparam logic [7:0] EXT24_LEN   = 8'h18;
  localparam logic [7:0] DMA_MAX_LEN = 8'h80;
  localparam logic [7:0] BEAT64_LEN  = 8'h08;
  localparam logic [7:0] BEAT32_LEN  = 8'h04;
  // Command codes on the command/byte-enable lines.
  localparam logic [3:0] CMD_INT_ACK    = 4'h0;
  localparam logic [3:0] CMD_IO_READ    = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE   = 4'h3;
  localparam logic [3:0] CMD_MEM_READ   = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE  = 4'h7;
  localparam logic [3:0] CMD_CFG_READ   = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE  = 4'hB;
  localparam logic [3:0] CMD_MEM_RD_MUL = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LN  = 4'hE;
  // Timing in link clock edges.
  localparam logic [2:0] DEVSEL_TIMEOUT = 3'd5;
  localparam logic [1:0] STOP_HOLDOFF   = 2'd2;
  // Request sources.
  typedef enum logic [1:0] {SRC_PROC, SRC_ALT_PCI, SRC_DMA, SRC_REG} source_e;
  typedef enum {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN} state_e;
endpackage : pci_master_pkg

// ---- tb/pci_master_initiator_assertions.sv ----
// Checker of the PCI initiator's arbitration, command and address behaviour.
`timescale 1ns/1ps
`default_nettype none
module pci_master_initiator_assertions
  import pci_master_pkg::*;
(
  // Clock, reset and APB.
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Source request.
  input wire logic        srcAccept,
  input wire logic        srcWrite,
  input wire logic        srcIo,
  input wire logic        srcCfg,
  input wire logic [31:0] srcAddr,
  input wire logic [7:0]  srcLen,
  input wire logic        srcTranslate,
  input wire logic [31:0] srcBlockMask,
  input wire logic [31:0] srcOffset,
  input wire logic        targetBusy,
  // Link pins.
  input wire logic        bus_grant_n,
  input wire logic        req_n,
  input wire logic        frame_n_o,
  input wire logic [3:0]  command_byte_enable_n_o,
  input wire logic [63:0] ad_o
);
  logic        en_q;
  logic        arb_q;
  logic [7:0]  cls_q;
  logic [3:0]  cmd_q;
  logic [31:0] adr_q;
  wire         wrStb = penable & pready & pwrite;
  wire         clsOk = pwdata[7:0] inside {CLS_16, CLS_32, CLS_64, CLS_128};
  // The command is caught at acceptance, since the request inputs are free to move after it.
  wire  [3:0]  cmd_d = srcCfg ? (srcWrite ? CMD_CFG_WRITE : CMD_CFG_READ)
                     : srcIo ? (srcWrite ? CMD_IO_WRITE : CMD_IO_READ)
                     : srcWrite ? CMD_MEM_WRITE : srcLen <= SINGLE_LEN ? CMD_MEM_READ
                     : srcLen <= cls_q ? CMD_MEM_RD_LN : CMD_MEM_RD_MUL;
  wire  [31:0] adr_d = srcTranslate ? (srcAddr & srcBlockMask) | (srcOffset & ~srcBlockMask)
                                    : srcAddr;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      {arb_q, en_q} <= 2'h0;
      cls_q         <= CACHE_LINE_RESET;
    end
    else
    begin
      if (wrStb && paddr == CTRL_OFFSET)
        {arb_q, en_q} <= {pwdata[ARB_EN_BIT], pwdata[INIT_EN_BIT]};
      if (wrStb && paddr == CACHE_LINE_OFFSET && clsOk)
        cls_q <= pwdata[7:0];
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srcAccept)
      {cmd_q, adr_q} <= {cmd_d, adr_d};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_accept_enabled: assert property (srcAccept |-> en_q)
    else $error("Request accepted while the initiator is disabled.");
  a_accept_idle: assert property (srcAccept |-> !$past(targetBusy))
    else $error("Request accepted while the target side was busy.");
  a_req_pin: assert property (srcAccept && !arb_q |-> !req_n)
    else $error("External request missing.");
  a_req_internal: assert property (arb_q |-> req_n)
    else $error("External request raised with the internal arbiter on.");
  a_frame_granted: assert property ($fell(frame_n_o) && !arb_q |-> !$past(bus_grant_n, 3))
    else $error("Frame opened without grant.");
  a_cmd_code: assert property ($fell(frame_n_o) |-> command_byte_enable_n_o == cmd_q)
    else $error("Wrong command code.");
  a_addr_out: assert property ($fell(frame_n_o) |-> ad_o[31:0] == adr_q)
    else $error("Wrong address.");
  a_wrinv_zero: assert property (pready && !pwrite && paddr == CTRL_OFFSET |-> !prdata[WR_INV_BIT])
    else $error("Write-and-invalidate enable reads as one.");
  c_read_line: cover property ($fell(frame_n_o) && command_byte_enable_n_o == CMD_MEM_RD_LN);
  c_internal_arb: cover property (srcAccept && arb_q);
  c_cache_line: cover property (wrStb && paddr == CACHE_LINE_OFFSET && clsOk);
endmodule : pci_master_initiator_assertions
bind pci_master_initiator pci_master_initiator_assertions u_checker
(
  .sys_clk, .srst, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .srcAccept, .srcWrite,
  .srcIo, .srcCfg, .srcAddr, .srcLen, .srcTranslate, .srcBlockMask, .srcOffset, .targetBusy,
  .bus_grant_n, .req_n, .frame_n_o, .command_byte_enable_n_o, .ad_o
);
`default_nettype wire

// ---- tb/pci_target_model.sv ----
// Behavioural PCI target and external arbiter facing the initiator.
`timescale 1ns/1ps
`default_nettype none
module pci_target_model
(
  // Link clock and wired initiator pins.
  input  wire logic        pciClk,
  input  wire logic        req_n,
  input  wire logic        frameW,
  input  wire logic        irdyW,
  // Scenario controls.
  input  wire logic        slow,
  input  wire logic        noClaim,
  // Arbiter and target pins.
  output logic             bus_grant_n,
  output logic             peerReq_n,
  output logic             devsel_n,
  output logic             trdy_n,
  output logic             stop_n,
  output logic [63:0]      adT
);
  initial
  begin
    {bus_grant_n, peerReq_n, devsel_n, trdy_n, stop_n} = 5'h1F;
    adT = 64'h0F1E2D3C4B5A6978;
  end
  // Read data toggles every clock so a stale sample never passes for fresh data.
  always @(posedge pciClk)
  begin
    bus_grant_n <= req_n;
    adT         <= ~adT;
    if (frameW & irdyW)
      {devsel_n, trdy_n} <= 2'h3;
    else if (!noClaim)
      {devsel_n, trdy_n} <= {1'b0, slow & ~trdy_n};
  end
endmodule : pci_target_model
`default_nettype wire

// ---- tb/test_pci_master_initiator.sv ----
// Self-checking bench of the PCI initiator with a behavioural target.
`timescale 1ns/1ps
`default_nettype none
module test_pci_master_initiator;
  import pci_master_pkg::*;
  logic        sys_clk, srst, pciClk, psel, penable, pwrite, pready, pslverr, srcReq;
  logic        srcWrite, srcIo, srcCfg, srcTranslate, targetBusy, slow, noClaim, srcAbort;
  logic        srcAccept, srcBeat, srcDone, req_n, bus_grant_n, peerReq_n, devsel_n;
  logic        trdy_n, stop_n, frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, ad_oe;
  logic        command_byte_enable_n_oe;
  logic [3:0]  command_byte_enable_n_o;
  logic [7:0]  srcLen;
  logic [11:0] paddr;
  logic [30:0] nb;
  logic [31:0] pwdata, prdata, srcAddr, srcBlockMask, srcOffset, failures, cmp_count;
  logic [63:0] srcWdata, ad_o, adT;
  logic [32:0] rdQ[$], doneQ[$];
  source_e     srcKind;
  logic [15:0] rows[15] = '{16'h2020, 16'h2420, 16'h2108, 16'h2408, 16'h2618, 16'h2010,
    16'h6040, 16'h7110, 16'hA4FF, 16'h0008, 16'h0420, 16'h4540, 16'h5004, 16'hC804, 16'hE804};
  // Released frame and irdy lines float high through their pull-ups; released AD lines carry the target's data.
  wire         frameW = frame_n_oe ? frame_n_o : 1'b1;
  wire         irdyW  = irdy_n_oe ? irdy_n_o : 1'b1;
  wire  [63:0] adW    = ad_oe ? ad_o : adT;
  pci_master_initiator u_dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .srcReq, .srcKind, .srcWrite, .srcIo, .srcCfg, .srcAddr,
    .srcLen, .srcTranslate, .srcBlockMask, .srcOffset, .srcWdata, .srcAccept, .srcBeat,
    .srcDone, .srcStopped(), .srcAbort, .srcRdata(), .targetBusy, .masterActive(), .pciClk,
    .bus_grant_n, .peerReq_n, .devsel_n, .trdy_n, .stop_n, .frame_n_i(frameW), .ad_i(adW),
    .req_n, .peerGrant_n(), .frame_n_o, .frame_n_oe, .irdy_n_o, .irdy_n_oe,
    .command_byte_enable_n_o, .command_byte_enable_n_oe, .ad_o, .ad_oe);
  pci_target_model u_target (.pciClk, .req_n, .frameW, .irdyW, .slow, .noClaim,
    .bus_grant_n, .peerReq_n, .devsel_n, .trdy_n, .stop_n, .adT);
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    if (!w)
      rdQ.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge sys_clk);
    {psel, penable} <= 2'h0;
  endtask : apb
  // Expected beats: extended processor writes shrink when disabled, I/O writes are single.
  function automatic logic [30:0] beats(input logic [15:0] r);
    logic [8:0] l;
    l = {1'b0, r[7:0]};
    if (r[15:13] == 3'h1 && !r[9] && (l == 9'h010 || l == 9'h018))
      l = 9'h008;
    if (r[15:14] == 2'h2 && l > 9'h080)
      l = 9'h080;
    if (r[13:12] == 2'h3)
      l = 9'h001;
    return r[10] ? 31'((l + 9'h007) >> 3) : 31'((l + 9'h003) >> 2);
  endfunction : beats
  task automatic xfer(input logic [15:0] r, input logic [32:0] e);
    int n;
    @(posedge sys_clk);
    {srcWrite, srcIo, srcCfg, srcLen, srcReq} <= {r[13:11], r[7:0], 1'b1};
    {srcAddr, srcOffset, srcBlockMask, srcWdata} <= {$urandom, $urandom, $urandom, $urandom, $urandom};
    srcKind      <= source_e'(r[15:14]);
    srcTranslate <= 1'($urandom);
    doneQ.push_back(e);
    for (n = 0; n < 400 && srcAccept !== 1'b1; n++)
      @(posedge sys_clk);
    srcReq <= 1'b0;
    for (n = 0; n < 4000 && srcDone !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      if (srcBeat === 1'b1)
        srcWdata <= {$urandom, $urandom};
    end
    repeat (24) @(posedge sys_clk);
  endtask : xfer
  task automatic blocked(input logic [31:0] ctl, input logic busy);
    apb(1'b1, CTRL_OFFSET, ctl, 33'h0);
    @(posedge sys_clk);
    {targetBusy, srcReq} <= {busy, 1'b1};
    repeat (60)
    begin
      @(posedge sys_clk);
      chk({32'h0, srcAccept | ~req_n}, 33'h0);
    end
    {targetBusy, srcReq} <= 2'h0;
  endtask : blocked
  always @(posedge sys_clk)
  begin
    if (srst)
      nb = '0;
    if (srcBeat === 1'b1)
      nb = nb + 31'h1;
    if (srcDone === 1'b1)
    begin
      chk({1'b0, srcAbort, nb}, doneQ.pop_front());
      nb = '0;
    end
    if (pready === 1'b1 && pwrite === 1'b0)
      chk({pslverr, prdata}, rdQ.pop_front());
  end
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    pciClk = 1'b0;
    #7 forever #80 pciClk = ~pciClk;
  end
  initial
  begin
    #1000000 failures = failures + 1;
    finish_test();
  end
  initial
  begin
    {psel, penable, pwrite, srcReq, srcIo, srcCfg, srcTranslate, targetBusy, slow} = '0;
    {paddr, pwdata, srcAddr, srcBlockMask, srcOffset, srcWdata, nb, noClaim} = '0;
    {srcWrite, srcLen, srcKind, srst, failures, cmp_count} = {1'b1, SINGLE_LEN, SRC_PROC, 1'b1, 64'h0};
    void'($urandom(75366));
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    apb(1'b0, CTRL_OFFSET, 32'h0, {28'h0, CTRL_RESET});
    apb(1'b0, CACHE_LINE_OFFSET, 32'h0, {25'h0, CACHE_LINE_RESET});
    apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, CTRL_OFFSET, 32'h1F, 33'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0, 33'h0F);
    apb(1'b1, CACHE_LINE_OFFSET, 32'h30, 33'h0);
    apb(1'b0, CACHE_LINE_OFFSET, 32'h0, 33'h20);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, CACHE_LINE_OFFSET, 32'h10 << (i % 4), 33'h0);
      apb(1'b0, CACHE_LINE_OFFSET, 32'h0, 33'h10 << (i % 4));
    end
    $display("Register test done.");
    blocked(32'h0, 1'b0);
    blocked(32'h1, 1'b1);
    $display("Refusal test done.");
    for (int i = 0; i < 15; i++)
    begin
      apb(1'b1, CTRL_OFFSET, {28'h0, rows[i][10:8], 1'b1}, 33'h0);
      slow <= 1'(i);
      xfer(rows[i], {2'h0, beats(rows[i])});
    end
    noClaim <= 1'b1;
    xfer(16'h2008, 33'h080000000);
    $display("Transfer test done.");
    finish_test();
  end
endmodule : test_pci_master_initiator
`default_nettype wire
